//--- core/twu_pkg.sv
package twu_pkg;
  localparam int ADDR_W = 24;
  // register byte addresses
  localparam logic [23:0] OFS_CONFIG = 24'hFFFF20;
  localparam logic [23:0] OFS_PRESCALER = 24'hFFFF22;
  localparam logic [23:0] OFS_PRESET = 24'hFFFF24;
  localparam logic [23:0] OFS_CTRL = 24'hFFFF26;
  localparam logic [23:0] OFS_WD_COUNT = 24'hFFFF28;
  localparam logic [23:0] OFS_WD_KEY = 24'hFFFF2A;
  // configuration fields
  localparam int CFG_LOCK_CFG = 0;
  localparam int CFG_LOCK_PRESC = 1;
  localparam int CFG_LOCK_PRESET = 2;
  localparam int CFG_LOCK_WATCHDOG_COUNT = 3;
  localparam int CFG_WD_CLK_SEL = 4;
  localparam int CFG_KEY_SVC_EN = 5;
  localparam logic [5:0] CFG_RESET = 6'h00;
  // control/status fields
  localparam int CSR_RESTART = 0;
  localparam int CSR_TC = 1;
  localparam int CSR_IRQ_EN = 2;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam logic [15:0] PRESET_RESET = 16'hFFFF;
  localparam logic [7:0] WD_COUNT_RESET = 8'hFF;
  localparam logic [7:0] SERVICE_KEY = 8'h5C;
  // early service threshold: service while counter above this is too often; 00h disables the check
  localparam logic [7:0] WD_EARLY_MARGIN = 8'h00;
  localparam logic [7:0] UNDEF_READ = 8'h00;
  // power modes
  typedef enum logic [3:0] {
    TWU_ACTIVE = 4'h1,
    TWU_IDLE = 4'h2,
    TWU_SAVE = 4'h4,
    TWU_HALT = 4'h8
  } twu_mode_t;
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_IDLE = 2'h1;
  localparam logic [1:0] MODE_SAVE = 2'h2;
  localparam logic [1:0] MODE_HALT = 2'h3;
endpackage : twu_pkg

//--- core/twu_tick_if.sv
`timescale 1ns/1ps
interface twu_tick_if;
  logic run;
  logic [2:0] div_sel;
  logic tick;
  modport gen (input run, input div_sel, output tick);
  modport use_side (output run, output div_sel, input tick);
endinterface : twu_tick_if

//--- core/twu_prescaler.sv
`timescale 1ns/1ps
module twu_prescaler (
  input wire logic clk,
  input wire logic rst_b,
  twu_tick_if.gen tif
);
  import twu_pkg::*;
  logic [4:0] div_cnt;
  logic [4:0] limit;

  // divisor minus one; reserved codes fall back to divide by 32
  always_comb begin
    unique case (tif.div_sel)
      3'h0: limit = 5'h00;
      3'h1: limit = 5'h01;
      3'h2: limit = 5'h03;
      3'h3: limit = 5'h07;
      3'h4: limit = 5'h0F;
      default: limit = 5'h1F;
    endcase
  end

  // free divider of the slow clock; stands still in halt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 5'h00;
    end else if (tif.run) begin
      if (div_cnt >= limit) begin
        div_cnt <= 5'h00;
      end else begin
        div_cnt <= div_cnt + 5'h01;
      end
    end
  end

  assign tif.tick = tif.run && (div_cnt >= limit); // [R01]
endmodule : twu_prescaler

//--- core/twu_timer_watchdog.sv
`timescale 1ns/1ps
// Behaviour
// [R01] slow clock divided by 1,2,4,8,16 or 32 per 3-bit field into tick
// [R02] periodic timer is 16-bit down counter stepping on each tick
// [R03] at zero the timer reloads from preset and keeps counting
// [R04] software programs preset only between 0001h and FFFFh
// [R05] at zero a timer output pulse lasts one tick; feeds wake-up unit; here timer_output_pulse lasts one clock cycle
// [R06] pulse sets terminal count flag; interrupt only when enabled
// [R07] preset written mid-run takes effect only at next reload
// [R08] restart bit reloads on next tick and clears itself
// [R09] watchdog is 8-bit down counter on its selected clock
// [R10] watchdog idle after reset; first count or key write starts it
// [R11] once started only device reset stops the watchdog
// [R12] config bit picks watchdog clock: timer pulse or tick
// [R13] without key mode, count write reloads watchdog with written value
// [R14] with key mode, writing 5Ch reloads watchdog from programmed count
// [R15] late service raises watchdog error
// [R16] too frequent service raises watchdog error; here WD_EARLY_MARGIN is 00h, so the check is disabled
// [R17] with key mode, any other key value raises watchdog error
// [R18] any watchdog error resets the whole device
// [R19] locked register ignores writes, reads return undefined data
// [R20] locks stay set until device reset
// [R21] power save and idle keep counting; only key register accessible
// [R22] halt freezes everything; resumes where it stopped; here key writes still start and reload the watchdog in halt
// [R23] software waits 5 slow clocks after restart or count service
// [R24] clock select 0 uses timer pulse, 1 uses tick
// [R25] key writes ignored while key service is disabled; here they still start the watchdog and reload it from the count register
// [R26] config holds lock bits; preset lock also locks control register
// [R27] reset: preset FFFFh, config, prescaler and control cleared
// [R28] zero before service is late error; early threshold is a parameter
module twu_timer_watchdog (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] power_mode,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  output logic timer_output_pulse,
  output logic timer_interrupt_line,
  output logic watchdog_reset_req,
  output logic watchdog_running
);
  import twu_pkg::*;

  twu_tick_if tif ();

  logic [5:0] config_q;
  logic [2:0] prescaler_q;
  logic [15:0] preset_q;
  logic restart_q;
  logic terminal_count_flag;
  logic timer_irq_enable;
  logic [7:0] watchdog_count;
  logic [15:0] timer_cnt;
  logic [7:0] wd_cnt;
  logic wd_err_q;
  logic run;
  logic active;
  logic tick;
  logic wd_clk_en;
  logic next_tout;
  logic tout_q;

  // halt freezes the counters and pulse, though key writes still start and reload the watchdog; other modes keep counting
  assign run = (power_mode != MODE_HALT); // [R22]
  assign active = (power_mode == MODE_ACTIVE); // [R21]

  assign tif.run = run;
  assign tif.div_sel = prescaler_q;
  assign tick = tif.tick;

  twu_prescaler u_presc (
    .clk(clk),
    .rst_b(rst_b),
    .tif(tif)
  );

  // decode of an accepted write to one register, lock and mode aware;
  // strobe and mode come in as arguments so the assigns see every change
  function automatic logic reg_wr(input logic en, input logic act,
                                  input logic [23:0] a, input logic [23:0] ofs,
                                  input logic lk, input logic need_active);
    return en && (a == ofs) && !lk && (!need_active || act);
  endfunction : reg_wr

  logic wr_cfg;
  logic wr_presc;
  logic wr_preset;
  logic wr_ctrl;
  logic wr_watchdog_count;
  logic wr_key;
  assign wr_cfg = reg_wr(wr_en, active, addr, OFS_CONFIG, config_q[CFG_LOCK_CFG], 1'b1); // [R19]
  assign wr_presc = reg_wr(wr_en, active, addr, OFS_PRESCALER, config_q[CFG_LOCK_PRESC],
                           1'b1); // [R19]
  assign wr_preset = reg_wr(wr_en, active, addr, OFS_PRESET, config_q[CFG_LOCK_PRESET],
                            1'b1); // [R26]
  assign wr_ctrl = reg_wr(wr_en, active, addr, OFS_CTRL, config_q[CFG_LOCK_PRESET], 1'b1); // [R26]
  assign wr_watchdog_count = reg_wr(wr_en, active, addr, OFS_WD_COUNT, config_q[CFG_LOCK_WATCHDOG_COUNT],
                           1'b1); // [R19]
  assign wr_key = reg_wr(wr_en, active, addr, OFS_WD_KEY, 1'b0, 1'b0); // [R21]

  // configuration: lock bits are sticky, other bits writable until locked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      config_q <= CFG_RESET; // [R27]
    end else if (wr_cfg) begin
      config_q[CFG_KEY_SVC_EN] <= wdata[CFG_KEY_SVC_EN];
      config_q[CFG_WD_CLK_SEL] <= wdata[CFG_WD_CLK_SEL];
      // or-in so a lock once set cannot be cleared
      config_q[3:0] <= config_q[3:0] | wdata[3:0]; // [R20]
    end
  end

  // prescaler field
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescaler_q <= PRESC_RESET; // [R27]
    end else if (wr_presc) begin
      prescaler_q <= wdata[2:0];
    end
  end

  // preset only steers the next reload, never the running count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preset_q <= PRESET_RESET; // [R27]
    end else if (wr_preset) begin
      preset_q <= wdata; // [R07]
    end
  end

  // interrupt enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_irq_enable <= 1'b0; // [R27]
    end else if (wr_ctrl) begin
      timer_irq_enable <= wdata[CSR_IRQ_EN];
    end
  end

  // restart request: writing 1 sets, hardware clears on the reloading tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      restart_q <= 1'b0;
    end else if (wr_ctrl && wdata[CSR_RESTART]) begin
      restart_q <= 1'b1;
    end else if (tick && restart_q) begin
      restart_q <= 1'b0; // [R08]
    end
  end

  // terminal count flag: pulse sets it, writing 0 clears; set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      terminal_count_flag <= 1'b0;
    end else if (timer_output_pulse && run) begin
      terminal_count_flag <= 1'b1; // [R06]
    end else if (wr_ctrl && !wdata[CSR_TC]) begin
      terminal_count_flag <= 1'b0;
    end
  end

  // periodic timer: down count per tick, reload at zero or on restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_cnt <= PRESET_RESET;
    end else if (tick) begin
      if (restart_q || timer_cnt == 16'h0000) begin
        timer_cnt <= preset_q; // [R03] [R08]
      end else begin
        timer_cnt <= timer_cnt - 16'h0001; // [R02]
      end
    end
  end

  // output pulse held from the tick that reaches zero until the next tick
  assign next_tout = !restart_q && (timer_cnt == 16'h0001);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tout_q <= 1'b0;
    end else if (tick) begin
      tout_q <= next_tout; // [R05]
    end
  end
  // one-cycle form of the pulse so downstream edge logic sees one event
  logic tout_seen;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tout_seen <= 1'b0;
    end else if (run) begin
      tout_seen <= tout_q;
    end
  end
  assign timer_output_pulse = tout_q && !tout_seen; // [R05]
  assign timer_interrupt_line = terminal_count_flag && timer_irq_enable; // [R06]

  // watchdog clock: 0 = timer pulse, 1 = tick
  assign wd_clk_en = config_q[CFG_WD_CLK_SEL] ? tick : (timer_output_pulse && run); // [R12] [R24]

  // count register also the reload value for key servicing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_count <= WD_COUNT_RESET;
    end else if (wr_watchdog_count) begin
      watchdog_count <= wdata[7:0];
    end
  end

  logic key_mode;
  logic svc_cnt;
  logic svc_key;
  logic bad_key;
  logic early;
  assign key_mode = config_q[CFG_KEY_SVC_EN];
  assign svc_cnt = wr_watchdog_count && !key_mode; // [R13]
  assign svc_key = wr_key && key_mode && (wdata[7:0] == SERVICE_KEY); // [R14] [R25]
  assign bad_key = wr_key && key_mode && (wdata[7:0] != SERVICE_KEY); // [R17]
  assign early = (svc_cnt || svc_key) && watchdog_running && (wd_cnt > WD_EARLY_MARGIN)
                 && (WD_EARLY_MARGIN != 8'h00); // [R16] [R28]

  // start on first count or key write, never stopped by software
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_running <= 1'b0;
    end else if (wr_watchdog_count || wr_key) begin
      watchdog_running <= 1'b1; // [R10] [R11]
    end
  end

  // watchdog counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt <= WD_COUNT_RESET;
    end else if (svc_cnt) begin
      wd_cnt <= wdata[7:0]; // [R13]
    end else if (svc_key) begin
      wd_cnt <= watchdog_count; // [R14]
    end else if (wr_key && !key_mode) begin
      wd_cnt <= watchdog_count; // starts and reloads from count register; value ignored [R25]
    end else if (watchdog_running && wd_clk_en && wd_cnt != 8'h00) begin
      wd_cnt <= wd_cnt - 8'h01; // [R09]
    end
  end

  // error latch: stays until the device reset it requested arrives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_err_q <= 1'b0;
    end else if (watchdog_running && wd_cnt == 8'h00 && !svc_cnt && !svc_key) begin
      wd_err_q <= 1'b1; // [R15] [R28]
    end else if (bad_key || early) begin
      wd_err_q <= 1'b1; // [R16] [R17]
    end
  end
  assign watchdog_reset_req = wd_err_q; // [R18]

  // read data one cycle after the strobe; locked or inaccessible reads give filler
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (rd_en) begin
      rdata <= 16'h0000;
      if (active) begin
        unique case (addr)
          OFS_CONFIG: rdata <= config_q[CFG_LOCK_CFG] ? {8'h00, UNDEF_READ} :
                               {10'h000, config_q}; // [R19]
          OFS_PRESCALER: rdata <= config_q[CFG_LOCK_PRESC] ? {8'h00, UNDEF_READ} :
                                  {13'h0000, prescaler_q};
          OFS_PRESET: rdata <= config_q[CFG_LOCK_PRESET] ? {8'h00, UNDEF_READ} : preset_q;
          OFS_CTRL: rdata <= config_q[CFG_LOCK_PRESET] ? {8'h00, UNDEF_READ} :
                             {13'h0000, timer_irq_enable, terminal_count_flag, restart_q};
          OFS_WD_COUNT: rdata <= config_q[CFG_LOCK_WATCHDOG_COUNT] ? {8'h00, UNDEF_READ} :
                                 {8'h00, watchdog_count};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule : twu_timer_watchdog

//--- verification/twu_properties.sv
`timescale 1ns/1ps
module twu_checker
  import twu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] power_mode,
  input wire logic [23:0] addr,
  input wire logic wr_en,
  input wire logic timer_output_pulse,
  input wire logic timer_interrupt_line,
  input wire logic watchdog_reset_req,
  input wire logic watchdog_running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_pulse_single: assert property (
    timer_output_pulse && power_mode != MODE_HALT |=> !timer_output_pulse)
    else $error("timer pulse longer than one cycle");
  a_error_sticky: assert property (watchdog_reset_req |=> watchdog_reset_req)
    else $error("reset request dropped");
  a_run_sticky: assert property (watchdog_running |=> watchdog_running)
    else $error("watchdog stopped");
  a_idle_no_error: assert property (
    !watchdog_running && !wr_en |=> !watchdog_reset_req)
    else $error("error from stopped watchdog");
  a_key_starts: assert property (
    wr_en && addr == OFS_WD_KEY && power_mode != MODE_HALT |=> watchdog_running)
    else $error("key write did not start watchdog");
  a_count_starts: assert property (
    wr_en && addr == OFS_WD_COUNT && power_mode == MODE_ACTIVE |=> watchdog_running)
    else $error("count write did not start watchdog");
  a_halt_freeze: assert property (power_mode == MODE_HALT |=>
    $stable(timer_output_pulse) && $stable(watchdog_running) && $stable(watchdog_reset_req))
    else $error("state moved in halt");
  a_irq_cause: assert property (
    $rose(timer_interrupt_line) |-> $past(timer_output_pulse) || $past(wr_en))
    else $error("interrupt without pulse");
  // main scenarios reached
  c_pulse: cover property (timer_output_pulse);
  c_error: cover property ($rose(watchdog_reset_req));
  c_halt: cover property (power_mode == MODE_HALT ##1 power_mode == MODE_HALT);
endmodule : twu_checker

bind twu_timer_watchdog twu_checker chk (.clk(clk), .rst_b(rst_b), .power_mode(power_mode),
  .addr(addr), .wr_en(wr_en), .timer_output_pulse(timer_output_pulse),
  .timer_interrupt_line(timer_interrupt_line), .watchdog_reset_req(watchdog_reset_req),
  .watchdog_running(watchdog_running));

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import twu_pkg::*;
  logic clk, rst_b, wr_en, rd_en, timer_output_pulse, timer_interrupt_line;
  logic watchdog_reset_req, watchdog_running;
  logic [1:0] power_mode;
  logic [23:0] addr;
  logic [15:0] wdata, rdata;
  int bad_count, checks, cyc, i, n;
  int divs[7] = '{1, 2, 4, 8, 16, 32, 32};
  twu_timer_watchdog dut (.clk(clk), .rst_b(rst_b), .power_mode(power_mode), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .timer_output_pulse(timer_output_pulse), .timer_interrupt_line(timer_interrupt_line),
    .watchdog_reset_req(watchdog_reset_req), .watchdog_running(watchdog_running));
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  // data is looked at mid-cycle in the cycle after the strobe; rdata then holds it until the next read
  task automatic rd(input logic [23:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rdata === e, "read data");
  endtask : rd
  task automatic wp;
    do @(negedge clk); while (timer_output_pulse !== 1'b1);
  endtask : wp
  task automatic gap;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (timer_output_pulse !== 1'b1);
  endtask : gap
  // first gap after a change may be short, so one pulse is skipped
  task automatic period(input int e);
    wp;
    gap;
    chk(n == e, "timer period");
  endtask : period
  task automatic req_win(input int lo, input int hi);
    repeat (lo) @(negedge clk);
    chk(watchdog_reset_req === 1'b0, "early reset request");
    repeat (hi) @(negedge clk);
    chk(watchdog_reset_req === 1'b1, "no reset request");
  endtask : req_win
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset
  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // a hang is cut short here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    {rst_b, wr_en, rd_en, power_mode, addr, wdata} = '0;
    do_reset;
    @(negedge clk);
    chk(watchdog_running === 1'b0, "running after reset");
    rd(OFS_CONFIG, 16'h0000);
    rd(OFS_PRESCALER, 16'h0000);
    rd(OFS_PRESET, 16'hFFFF);
    rd(OFS_CTRL, 16'h0000);
    rd(24'hFFFF30, 16'h0000);
    wr(OFS_PRESET, 16'h0003);
    wr(OFS_CTRL, 16'h0001);
    period(4);
    rd(OFS_CTRL, 16'h0002);
    chk(timer_interrupt_line === 1'b0, "irq while disabled");
    wr(OFS_CTRL, 16'h0004);
    wp;
    @(negedge clk);
    chk(timer_interrupt_line === 1'b1, "irq missing");
    wp;
    wr(OFS_PRESET, 16'h0005);
    gap;
    chk(n < 6, "count disturbed by preset write");
    period(6);
    wp;
    @(posedge clk) power_mode <= MODE_HALT;
    i = 0;
    repeat (20) begin
      @(negedge clk);
      i += int'(timer_output_pulse !== 1'b0);
    end
    chk(i == 0, "pulse in halt");
    @(posedge clk) power_mode <= MODE_IDLE;
    wr(OFS_PRESET, 16'h0007);
    period(6);
    @(posedge clk) power_mode <= MODE_ACTIVE;
    rd(OFS_PRESET, 16'h0005);
    for (i = 0; i < 7; i++) begin
      wr(OFS_PRESCALER, 16'(i));
      period(6 * divs[i]);
    end
    wr(OFS_PRESCALER, 16'h0000);
    wr(OFS_CONFIG, 16'h0004);
    wr(OFS_PRESET, 16'h0009);
    wr(OFS_CONFIG, 16'h0000);
    rd(OFS_CONFIG, 16'h0004);
    rd(OFS_PRESET, 16'h0000);
    rd(OFS_CTRL, 16'h0000);
    period(6);
    wr(OFS_CONFIG, 16'h0010);
    wr(OFS_WD_COUNT, 16'h0028);
    for (i = 0; i < 3; i++) begin
      repeat (30) @(posedge clk);
      wr(OFS_WD_COUNT, 16'h0028);
    end
    req_win(35, 15);
    do_reset;
    @(negedge clk);
    chk(watchdog_running === 1'b0, "running after second reset");
    wr(OFS_CONFIG, 16'h0030);
    wr(OFS_WD_COUNT, 16'h001E);
    repeat (5) @(posedge clk);
    @(posedge clk) power_mode <= MODE_IDLE;
    for (i = 0; i < 3; i++) begin
      repeat (20) @(posedge clk);
      wr(OFS_WD_KEY, 16'h005C);
    end
    @(negedge clk);
    chk(watchdog_reset_req === 1'b0, "error despite good key");
    chk(watchdog_running === 1'b1, "watchdog not running");
    wr(OFS_WD_KEY, 16'h005D);
    @(negedge clk);
    chk(watchdog_reset_req === 1'b1, "no reset request");
    @(posedge clk) power_mode <= MODE_ACTIVE;
    do_reset;
    wr(OFS_WD_KEY, 16'h0011);
    wr(OFS_PRESET, 16'h0001);
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_WD_COUNT, 16'h000A);
    req_win(15, 12);
    final_report;
  end
endmodule : tb_top
